// >>> hw/gssm_defs.svh
// Purpose: Constants for the gyro SPI status message block.
// Assumes: 50 MHz system clock; SPI mode 0 from an external master.
// Notes:   Offsets, field positions, reset values and counts live here.
// Function
// - Mode 0 six-byte full-duplex exchange, slave.
// - Last byte is inverted sum of five.
// - Command bit 5 selects range source.
// - Command bit 6 enables commanded self-test offset.
// - Status bit 7 set on failed checks.
// - Fail flag forced while self-test enabled.
// - Status bits 6..5 message type 00.
// - Status bit 4 flags bad previous command.
// - Bad command keeps last valid settings.
// - Status bit 3 shows self-test enabled.
// - Status bit 2 always zero.
// - Status bits 1..0 report active range.
// - Bytes 2,3 carry signed rate, MSB first.
// - Rate scale depends on active range.
// - Bytes 4,5 carry unsigned temperature, MSB first.
// - Temperature 0213h at zero, 2.75 per degree.
// - Sixth status byte is a checksum.
`ifndef GSSM_DEFS_SVH
`define GSSM_DEFS_SVH

// ============================================================
// Message geometry
`define GSSM_MSG_BYTES      6
`define GSSM_MSG_BITS       48
`define GSSM_BITCNT_W       6

// ============================================================
// Command byte fields
`define GSSM_CMD_FACTORY    7
`define GSSM_CMD_SELFTEST   6
`define GSSM_CMD_RSRC       5
`define GSSM_CMD_RANGE_HI   4
`define GSSM_CMD_RANGE_LO   3

// ============================================================
// Status byte fields
`define GSSM_ST_FAIL        7
`define GSSM_ST_TYPE_HI     6
`define GSSM_ST_TYPE_LO     5
`define GSSM_ST_BADCMD      4
`define GSSM_ST_SELFTEST    3
`define GSSM_ST_ZERO        2
`define GSSM_MSG_TYPE_DATA  2'h0

// ============================================================
// Range codes and reset values
`define GSSM_RANGE_900      2'h0
`define GSSM_RANGE_300      2'h1
`define GSSM_RANGE_150      2'h2
`define GSSM_RANGE_75       2'h3
`define GSSM_RANGE_RST      2'h3
`define GSSM_TEMP_ZERO_C    16'h0213

`endif

// >>> hw/gssm_pkg.sv
// Purpose: Types for the gyro SPI status message block.
// Assumes: Constants come from gssm_defs.svh.
// Notes:   Types only.
package gssm_pkg;
    // ============================================================
    // Link state: idle between frames, shifting inside one.
    typedef enum logic [1:0] {
        GSSM_IDLE  = 2'b01,
        GSSM_SHIFT = 2'b10
    } gssm_state_t;
endpackage

// >>> hw/gssm_top.sv
// Purpose: SPI slave that returns the six-byte status message.
// Assumes: SPI pins are asynchronous; the SPI clock is far slower
//          than clk_sys so edges are found by oversampling.
// Notes:   Rate and temperature come in as ready words from the
//          measurement path through a two-entry buffer.
`timescale 1ns/1ps
`include "gssm_defs.svh"

module gssm_top #(
    parameter int RATE_W = 16
) (
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    input  wire logic              spi_sclk,
    input  wire logic              spi_ss_n,
    input  wire logic              spi_mosi,
    output logic                   spi_miso,
    output logic                   spi_miso_oe_n,
    input  wire logic              meas_valid,
    output logic                   meas_ready,
    input  wire logic [RATE_W-1:0] meas_rate,
    input  wire logic [15:0]       meas_temp,
    input  wire logic              check_fail,
    output logic                   self_test_en,
    output logic [1:0]             range_sel,
    output logic                   cmd_bad,
    output logic                   msg_done
);

    // ============================================================
    // Reset release and input synchronisers.
    logic       rst_a_ff, rst_b_ff;
    logic [1:0] sclk_s_ff, ss_s_ff, mosi_s_ff;
    logic       sclk_d_ff, ss_d_ff;
    logic       rst_n;
    assign rst_n = rst_b_ff;

    // Reset is asserted at once but released through two stages.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_a_ff <= 1'b0;
            rst_b_ff <= 1'b0;
        end else begin
            rst_a_ff <= 1'b1;
            rst_b_ff <= rst_a_ff;
        end
    end

    // Only stage one of each synchroniser feeds stage two.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sclk_s_ff <= 2'h0;
            ss_s_ff   <= 2'h3;
            mosi_s_ff <= 2'h0;
            sclk_d_ff <= 1'b0;
            ss_d_ff   <= 1'b1;
        end else begin
            sclk_s_ff <= {sclk_s_ff[0], spi_sclk};
            ss_s_ff   <= {ss_s_ff[0], spi_ss_n};
            mosi_s_ff <= {mosi_s_ff[0], spi_mosi};
            sclk_d_ff <= sclk_s_ff[1];
            ss_d_ff   <= ss_s_ff[1];
        end
    end

    logic sclk_rise, sclk_fall, ss_fall, ss_rise, ss_low;
    assign ss_low    = ~ss_s_ff[1];
    assign ss_fall   = ss_d_ff & ~ss_s_ff[1];
    assign ss_rise   = ~ss_d_ff & ss_s_ff[1];
    assign sclk_rise = ss_low & ~sclk_d_ff & sclk_s_ff[1];
    assign sclk_fall = ss_low & sclk_d_ff & ~sclk_s_ff[1];

    // ============================================================
    // Checksum: inverted low byte of the sum of five bytes.
    function automatic logic [7:0] gssm_csum(input logic [39:0] b);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 5; i++) begin
            s = s + b[i*8 +: 8];
        end
        return ~s;
    endfunction

    // ============================================================
    // Two-entry buffer for measurement words.
    logic [RATE_W+15:0] buf_ff [2];
    logic [1:0]         buf_cnt_ff;
    logic               buf_rd_ff, buf_wr_ff;
    logic               buf_push, buf_pop;
    logic [RATE_W+15:0] meas_ff;

    // Drained only at a frame start, so an idle link stalls the source.
    assign buf_push = meas_valid && meas_ready;
    assign buf_pop  = ss_fall && (buf_cnt_ff != 2'h0);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            buf_cnt_ff <= 2'h0;
            buf_rd_ff  <= 1'b0;
            buf_wr_ff  <= 1'b0;
            meas_ready <= 1'b0;
            buf_ff[0]  <= '0;
            buf_ff[1]  <= '0;
        end else begin
            if (buf_push) begin
                buf_ff[buf_wr_ff] <= {meas_rate, meas_temp};
                buf_wr_ff         <= ~buf_wr_ff;
            end
            if (buf_pop) begin
                buf_rd_ff <= ~buf_rd_ff;
            end
            buf_cnt_ff <= buf_cnt_ff + {1'b0, buf_push} - {1'b0, buf_pop};
            meas_ready <= (buf_cnt_ff + {1'b0, buf_push}
                           - {1'b0, buf_pop}) < 2'h2;
        end
    end

    // The newest popped word is kept so every frame has data.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meas_ff <= {{RATE_W{1'b0}}, `GSSM_TEMP_ZERO_C};
        end else if (buf_pop) begin
            meas_ff <= buf_ff[buf_rd_ff];
        end
    end

    // ============================================================
    // Status message assembly.
    logic [7:0]  st_byte;
    logic [39:0] st_body;
    logic [RATE_W-1:0] rate_word;

    always_comb begin
        st_byte = 8'h00;
        st_byte[`GSSM_ST_FAIL] = check_fail | self_test_en;
        st_byte[`GSSM_ST_TYPE_HI:`GSSM_ST_TYPE_LO] =
            `GSSM_MSG_TYPE_DATA;
        st_byte[`GSSM_ST_BADCMD]   = cmd_bad;
        st_byte[`GSSM_ST_SELFTEST] = self_test_en;
        st_byte[`GSSM_ST_ZERO]     = 1'b0;
        st_byte[1:0] = range_sel;
    end

    // Rate arrives already scaled for the active range; the
    // measurement path also adds the self-test offset.
    assign rate_word = meas_ff[RATE_W+15:16];
    // Temperature is passed through as an unsigned code.
    assign st_body = {st_byte, rate_word[15:0],
                      meas_ff[15:0]};

    // ============================================================
    // Link state and shift registers.
    gssm_pkg::gssm_state_t state_ff;
    logic [47:0]            tx_ff, rx_ff;
    logic [`GSSM_BITCNT_W-1:0] bitcnt_ff;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= gssm_pkg::GSSM_IDLE;
        end else begin
            unique case (state_ff)
                gssm_pkg::GSSM_IDLE: begin
                    if (ss_fall) begin
                        state_ff <= gssm_pkg::GSSM_SHIFT;
                    end
                end
                gssm_pkg::GSSM_SHIFT: begin
                    if (ss_rise) begin
                        state_ff <= gssm_pkg::GSSM_IDLE;
                    end
                end
                default: state_ff <= gssm_pkg::GSSM_IDLE;
            endcase
        end
    end

    // Snapshot the whole message at the frame start so the words
    // cannot tear mid-transfer; a pending pop is taken in first.
    logic [39:0] snap_body;
    assign snap_body = buf_pop ?
        {st_byte, buf_ff[buf_rd_ff][RATE_W+15:RATE_W],
         buf_ff[buf_rd_ff][15:0]} : st_body;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_ff     <= 48'h0000_0000_0000;
            rx_ff     <= 48'h0000_0000_0000;
            bitcnt_ff <= '0;
        end else if (ss_fall) begin
            tx_ff     <= {snap_body, gssm_csum(snap_body)};
            bitcnt_ff <= '0;
        end else if (sclk_rise) begin
            rx_ff     <= {rx_ff[46:0], mosi_s_ff[1]};
            bitcnt_ff <= bitcnt_ff + 1'b1;
        end else if (sclk_fall) begin
            tx_ff <= {tx_ff[46:0], 1'b0};
        end
    end

    // MSB drives at once in mode 0, then shifts on falling edges.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            spi_miso      <= 1'b0;
            spi_miso_oe_n <= 1'b1;
        end else begin
            spi_miso      <= tx_ff[47];
            spi_miso_oe_n <= ~ss_low;
        end
    end

    // ============================================================
    // Command handling at frame end.
    logic [7:0] cmd_byte;
    logic       cmd_ok, full_frame;
    assign cmd_byte   = rx_ff[47:40];
    assign full_frame = bitcnt_ff == 6'(`GSSM_MSG_BITS);
    assign cmd_ok     = full_frame &&
                        gssm_csum(rx_ff[47:8]) == rx_ff[7:0];

    // Only a whole, valid frame changes settings; others keep
    // the last good ones. Factory-mode commands are not honoured.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            self_test_en <= 1'b0;
            range_sel    <= `GSSM_RANGE_RST;
            cmd_bad      <= 1'b0;
            msg_done     <= 1'b0;
        end else begin
            msg_done <= ss_rise && state_ff == gssm_pkg::GSSM_SHIFT;
            if (ss_rise && state_ff == gssm_pkg::GSSM_SHIFT) begin
                cmd_bad <= ~cmd_ok;
                if (cmd_ok && !cmd_byte[`GSSM_CMD_FACTORY]) begin
                    self_test_en <= cmd_byte[`GSSM_CMD_SELFTEST];
                    range_sel <= cmd_byte[`GSSM_CMD_RSRC] ?
                        cmd_byte[`GSSM_CMD_RANGE_HI:`GSSM_CMD_RANGE_LO] :
                        `GSSM_RANGE_75;
                end
            end
        end
    end

    // ============================================================
    // Checks.
    sequence s_frame_end;
        ss_rise && state_ff == gssm_pkg::GSSM_SHIFT;
    endsequence

    a_fail_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
        self_test_en |-> st_byte[7])
        else $error("fail flag low in self-test");
    a_fail_check: assert property (@(posedge clk_sys) disable iff (!rst_n)
        st_byte[7] == (check_fail | self_test_en))
        else $error("fail flag wrong");
    a_type_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
        st_byte[6:4] == {2'b00, cmd_bad} && !st_byte[2])
        else $error("type or zero bit wrong");
    a_selftest_bit: assert property (@(posedge clk_sys) disable iff (!rst_n)
        st_byte[3] == self_test_en && st_byte[1:0] == range_sel)
        else $error("self-test or range bit wrong");
    a_snap_csum: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ss_fall |=> tx_ff[7:0] == gssm_csum(tx_ff[47:8]))
        else $error("status checksum wrong");
    a_bad_cmd: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_frame_end ##0 !cmd_ok |=> cmd_bad && $stable(range_sel))
        else $error("bad command changed settings");
    a_good_cmd: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_frame_end ##0 cmd_ok |=> !cmd_bad ##0 msg_done)
        else $error("good command not accepted");
    // The data pin must be driven for the whole selected frame.
    a_oe_frame: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ss_low |=> !spi_miso_oe_n)
        else $error("data pin not driven while selected");
    a_hold_frame: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_ff == gssm_pkg::GSSM_SHIFT && !ss_rise
        |=> $stable(range_sel))
        else $error("settings changed mid frame");

endmodule

// >>> verif/gssm_host_model.sv
// Purpose: Host SPI master model that trades six-byte messages.
// Assumes: Mode 0; every pin moves on the falling edge of clk_sys.
// Notes:   The serial clock stands low between frames.
`timescale 1ns/1ps

module gssm_host_model #(
    parameter int HALF = 4,
    parameter int GAP  = 4600
) (
    input  wire logic clk_sys,
    output logic      spi_sclk,
    output logic      spi_ss_n,
    output logic      spi_mosi,
    input  wire logic spi_miso
);
    // ============================================================
    // Idle levels
    // The clock stays low and select high until a frame starts.
    initial begin
        spi_sclk = 1'b0;
        spi_ss_n = 1'b1;
        spi_mosi = 1'b0;
    end

    // ============================================================
    // Frame engine
    // The checksum is added here; corrupt flips its last bit.
    // A short frame stops after nbits, which the slave must refuse.
    // Data is read at the end of the high phase, because the slave
    // updates it several system clocks after each falling edge.
    task automatic xfer(input  logic [39:0] body,
                        input  bit          corrupt,
                        input  int          nbits,
                        output logic [47:0] rx);
        logic [47:0] tx;
        tx = {body, ~(body[39:32] + body[31:24] + body[23:16]
                      + body[15:8] + body[7:0])};
        tx[0] = tx[0] ^ corrupt;
        rx = 48'h0000_0000_0000;
        repeat (GAP) @(negedge clk_sys);
        spi_ss_n = 1'b0;
        repeat (2 * HALF) @(negedge clk_sys);
        for (int i = 47; i >= 48 - nbits; i--) begin
            spi_mosi = tx[i];
            repeat (HALF) @(negedge clk_sys);
            spi_sclk = 1'b1;
            repeat (HALF) @(negedge clk_sys);
            rx[i] = spi_miso;
            spi_sclk = 1'b0;
        end
        repeat (HALF) @(negedge clk_sys);
        spi_ss_n = 1'b1;
        spi_mosi = ~spi_mosi;
    endtask
endmodule

// >>> verif/test_gssm_top.sv
// Purpose: Self-checking bench for the status message slave.
// Assumes: Host model paces frames near 10 kHz at 6.25 MHz sclk.
// Notes:   Expected status is tracked from the commands sent.
`timescale 1ns/1ps
`include "gssm_defs.svh"

`define CHK(got, exp) begin samples_checked++; \
    if ((got) !== (exp)) begin fails++; \
    $display("BAD t=%0t got %h exp %h", $time, got, exp); end end

module test_gssm_top;
    logic        clk_sys    = 1'b0;
    logic        rstn       = 1'b0;
    logic        spi_sclk;
    logic        spi_ss_n;
    logic        spi_mosi;
    logic        spi_miso;
    logic        spi_miso_oe_n;
    logic        meas_valid = 1'b0;
    logic        meas_ready;
    logic [15:0] meas_rate  = 16'h0000;
    logic [15:0] meas_temp  = 16'h0000;
    logic        check_fail = 1'b0;
    logic        self_test_en;
    logic [1:0]  range_sel;
    logic        cmd_bad;
    logic        msg_done;
    int          fails           = 0;
    int          samples_checked = 0;
    int          cycles          = 0;
    logic        st_e  = 1'b0;
    logic [1:0]  rng_e = `GSSM_RANGE_RST;
    logic        bad_e = 1'b0;

    gssm_top #(.RATE_W(16)) i_dut (
        .clk_sys      (clk_sys),
        .rstn         (rstn),
        .spi_sclk     (spi_sclk),
        .spi_ss_n     (spi_ss_n),
        .spi_mosi     (spi_mosi),
        .spi_miso     (spi_miso),
        .spi_miso_oe_n(spi_miso_oe_n),
        .meas_valid   (meas_valid),
        .meas_ready   (meas_ready),
        .meas_rate    (meas_rate),
        .meas_temp    (meas_temp),
        .check_fail   (check_fail),
        .self_test_en (self_test_en),
        .range_sel    (range_sel),
        .cmd_bad      (cmd_bad),
        .msg_done     (msg_done)
    );

    gssm_host_model i_host (
        .clk_sys (clk_sys),
        .spi_sclk(spi_sclk),
        .spi_ss_n(spi_ss_n),
        .spi_mosi(spi_mosi),
        .spi_miso(spi_miso)
    );

    // ============================================================
    // Clock and watchdog
    // The ceiling sits above twelve paced frames so a hang is cut.
    always #10 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 70000) begin
            fails++;
            report_and_stop();
        end
    end

    // ============================================================
    // Tasks
    // Prints the counts and the verdict, then ends the run.
    task report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Offers one word and holds it until ready is seen high.
    task push(input logic [15:0] r, input logic [15:0] t);
        @(negedge clk_sys);
        meas_valid = 1'b1;
        meas_rate  = r;
        meas_temp  = t;
        while (meas_ready !== 1'b1) @(negedge clk_sys);
        @(negedge clk_sys);
        meas_valid = 1'b0;
    endtask

    // Runs one frame, checks the reply of a full frame, then the applied settings.
    task frame(input logic [7:0] cmd, input bit corrupt, input int nbits,
               input bit cf, input logic [15:0] re, input logic [15:0] te);
        logic [47:0] rx;
        logic [47:0] exp_msg;
        logic [7:0]  stat;
        bit          good;
        check_fail = cf;
        stat = {cf | st_e, `GSSM_MSG_TYPE_DATA, bad_e, st_e, 1'b0, rng_e};
        exp_msg = {stat, re, te,
                   ~(stat + re[15:8] + re[7:0] + te[15:8] + te[7:0])};
        i_host.xfer({cmd, 32'h0000_0000}, corrupt, nbits, rx);
        check_fail = 1'b0;
        if (nbits == 48) `CHK(rx, exp_msg)
        good = (nbits == 48) && !corrupt;
        if (good && !cmd[7]) begin
            st_e  = cmd[6];
            rng_e = cmd[5] ? cmd[4:3] : `GSSM_RANGE_75;
        end
        bad_e = !good;
        for (int k = 0; k < 20 && msg_done !== 1'b1; k++) begin
            @(negedge clk_sys);
        end
        `CHK(msg_done, 1'b1)
        `CHK(range_sel, rng_e)
        `CHK(self_test_en, st_e)
        `CHK(cmd_bad, bad_e)
        `CHK(spi_miso_oe_n, 1'b1)
    endtask

    // ============================================================
    // Main sequence
    // Later frames find the buffer empty and reuse the last word.
    initial begin
        repeat (5) @(negedge clk_sys);
        rstn = 1'b1;
        frame(8'h00, 0, 48, 0, 16'h0000, `GSSM_TEMP_ZERO_C);
        push(16'h12C0, 16'h01A5);
        push(16'hF4C0, 16'h02FD);
        repeat (3) @(negedge clk_sys);
        `CHK(meas_ready, 1'b0)
        frame(8'h30, 0, 48, 0, 16'h12C0, 16'h01A5);
        frame(8'h28, 0, 48, 0, 16'hF4C0, 16'h02FD);
        frame(8'h20, 0, 48, 0, 16'hF4C0, 16'h02FD);
        frame(8'h38, 0, 48, 1, 16'hF4C0, 16'h02FD);
        frame(8'h40, 0, 48, 0, 16'hF4C0, 16'h02FD);
        frame(8'h30, 0, 48, 0, 16'hF4C0, 16'h02FD);
        frame(8'h28, 1, 48, 0, 16'hF4C0, 16'h02FD);
        frame(8'h80, 0, 48, 0, 16'hF4C0, 16'h02FD);
        frame(8'h28, 0, 40, 0, 16'hF4C0, 16'h02FD);
        frame(8'h00, 0, 48, 0, 16'hF4C0, 16'h02FD);
        report_and_stop();
    end
endmodule
